/* File: design/timer16_pkg.sv */
package timer16_pkg;

    localparam int unsigned CW = 16;
    localparam int unsigned AW = 8;

    // register byte offsets
    localparam logic [AW-1:0] OFS_TIMER_CTRL_A      = 8'h00;
    localparam logic [AW-1:0] OFS_COUNT_VALUE       = 8'h04;
    localparam logic [AW-1:0] OFS_CHAN_A_COMPARE    = 8'h08;
    localparam logic [AW-1:0] OFS_CHAN_B_COMPARE    = 8'h0C;
    localparam logic [AW-1:0] OFS_CAPTURE_VALUE     = 8'h10;
    localparam logic [AW-1:0] OFS_TIMER_FLAG_REG    = 8'h14;
    localparam logic [AW-1:0] OFS_WAVE_PIN_DIR      = 8'h18;

    // timer_ctrl_a field positions
    localparam int unsigned MODE_LSB  = 0;
    localparam int unsigned ACT_A_LSB = 4;
    localparam int unsigned ACT_B_LSB = 6;
    localparam int unsigned PSC_LSB   = 8;
    localparam logic [CW-1:0] CTRL_MASK = 16'h07FF;

    // timer_flag_reg bit positions
    localparam int unsigned FLG_OVF = 0;
    localparam int unsigned FLG_MA  = 1;
    localparam int unsigned FLG_MB  = 2;
    localparam int unsigned FLG_CAP = 3;

    // wave_mode_select codes
    localparam logic [3:0] MODE_NORMAL   = 4'h0;
    localparam logic [3:0] MODE_CTC_CMP  = 4'h4;
    localparam logic [3:0] MODE_FPWM_8   = 4'h5;
    localparam logic [3:0] MODE_FPWM_9   = 4'h6;
    localparam logic [3:0] MODE_FPWM_10  = 4'h7;
    localparam logic [3:0] MODE_CTC_CAP  = 4'hC;
    localparam logic [3:0] MODE_FPWM_CAP = 4'hE;
    localparam logic [3:0] MODE_FPWM_CMP = 4'hF;

    // compare_output_action codes
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    // fixed tops and counter extremes
    localparam logic [CW-1:0] TOP_8BIT  = 16'h00FF;
    localparam logic [CW-1:0] TOP_9BIT  = 16'h01FF;
    localparam logic [CW-1:0] TOP_10BIT = 16'h03FF;
    localparam logic [CW-1:0] CNT_MAX   = 16'hFFFF;
    localparam logic [CW-1:0] CNT_BOT   = 16'h0000;

    // prescale select codes 1..5 give divide by 1, 8, 64, 256, 1024
    localparam int unsigned PSW = 10;
    localparam logic [PSW-1:0] PSC_MASK_1    = 10'h000;
    localparam logic [PSW-1:0] PSC_MASK_8    = 10'h007;
    localparam logic [PSW-1:0] PSC_MASK_64   = 10'h03F;
    localparam logic [PSW-1:0] PSC_MASK_256  = 10'h0FF;
    localparam logic [PSW-1:0] PSC_MASK_1024 = 10'h3FF;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] out;
        logic [1:0] oe;
    } wave_pins_t;

    typedef struct packed {
        logic [CW-1:0]  ctrl;
        logic [CW-1:0]  cnt;
        logic [CW-1:0]  cmp_a;
        logic [CW-1:0]  cmp_b;
        logic [CW-1:0]  buf_a;
        logic [CW-1:0]  buf_b;
        logic [CW-1:0]  cap;
        logic [3:0]     flags;
        logic [1:0]     dir;
        logic [1:0]     oc;
        logic           block;
        logic [PSW-1:0] psc;
        logic           aw_full;
        logic [AW-1:0]  aw_addr;
        logic           w_full;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } state_t;

    localparam state_t STATE_RST = '0;

endpackage

/* File: design/timer16_waveform_modes.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - only mode select shapes counting
// RULE_02 - non-PWM: action sets, clears or toggles on match
// RULE_03 - mode 0x0 counts up, wraps 0xFFFF to 0x0000
// RULE_04 - normal: overflow flag as count becomes zero
// RULE_05 - normal: counter may be loaded any time
// RULE_06 - clear-on-match at TOP: A compare (0x4) or capture (0xC)
// RULE_07 - clear-on-match TOP acts at once; low TOP wraps first
// RULE_08 - clear-on-match flags A or capture at TOP
// RULE_09 - clear-on-match action 0x1 toggles channel A
// RULE_10 - pin driven only while direction bit is set
// RULE_11 - clear-on-match: overflow flag on max to 0x0000
// RULE_12 - 0x5, 0x6, 0x7, 0xE, 0xF: fast PWM up to TOP
// RULE_13 - fast PWM TOP 0x00FF/0x01FF/0x03FF, capture or A
// RULE_14 - fast PWM clears on tick after TOP match
// RULE_15 - fast PWM: match and BOTTOM set opposite levels
// RULE_16 - actions 0x2 and 0x3 pick PWM polarity
// RULE_17 - fast PWM: overflow and TOP flag at TOP
// RULE_18 - fixed TOP masks compare writes
// RULE_19 - fast PWM compare writes buffered until TOP
// RULE_20 - capture TOP acts at once; low TOP wraps first
// RULE_21 - software keeps TOP at or above compares
// RULE_22 - register TOP from 0x0003 to 0xFFFF
// RULE_23 - tick divides by 1, 8, 64, 256 or 1024
// RULE_24 - action zero leaves compare state alone
// RULE_25 - match flag at next tick; write one clears
// RULE_26 - reset clears compare state
// RULE_27 - state advances only on prescaler ticks
module timer16_waveform_modes
    import timer16_pkg::*;
#(
    parameter logic [1:0] PWM_INVERT_ACTION = ACT_CLEAR
) (
    // clock and reset
    input  wire logic           aclk,
    input  wire logic           aresetn,
    // axi4-lite write address
    input  wire logic [AW-1:0]  s_axi_awaddr,
    input  wire logic [2:0]     s_axi_awprot,
    input  wire logic           s_axi_awvalid,
    output      logic           s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]    s_axi_wdata,
    input  wire logic [3:0]     s_axi_wstrb,
    input  wire logic           s_axi_wvalid,
    output      logic           s_axi_wready,
    // axi4-lite write response
    output      logic [1:0]     s_axi_bresp,
    output      logic           s_axi_bvalid,
    input  wire logic           s_axi_bready,
    // axi4-lite read address
    input  wire logic [AW-1:0]  s_axi_araddr,
    input  wire logic [2:0]     s_axi_arprot,
    input  wire logic           s_axi_arvalid,
    output      logic           s_axi_arready,
    // axi4-lite read data
    output      logic [31:0]    s_axi_rdata,
    output      logic [1:0]     s_axi_rresp,
    output      logic           s_axi_rvalid,
    input  wire logic           s_axi_rready,
    // port pins shared with the compare outputs
    input  wire logic [1:0]     port_data,
    output      wave_pins_t     wave_pins,
    // compare state and flags seen directly
    output      logic [1:0]     chan_wave_out,
    output      logic [3:0]     timer_flags
);

    state_t s_q;
    state_t s_d;

    ////////////////////////////////////////////////////////////////////////////////

    function automatic logic [CW-1:0] merge16(input logic [CW-1:0] old,
                                              input logic [31:0]   data,
                                              input logic [3:0]    strb);
        logic [CW-1:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    function automatic logic is_fpwm(input logic [3:0] m);
        return (m == MODE_FPWM_8) || (m == MODE_FPWM_9) || (m == MODE_FPWM_10) ||
               (m == MODE_FPWM_CAP) || (m == MODE_FPWM_CMP);
    endfunction

    // low-bit mask for fixed tops, all ones otherwise
    function automatic logic [CW-1:0] fixed_mask(input logic [3:0] m);
        unique case (m)
            MODE_FPWM_8:  return TOP_8BIT;
            MODE_FPWM_9:  return TOP_9BIT;
            MODE_FPWM_10: return TOP_10BIT;
            default:      return CNT_MAX;
        endcase
    endfunction

    function automatic logic psc_tick(input logic [2:0]     sel,
                                      input logic [PSW-1:0] cnt);
        logic [PSW-1:0] m;
        logic           run;
        m   = PSC_MASK_1;
        run = 1'b1;
        unique case (sel)
            3'h1:    m = PSC_MASK_1;
            3'h2:    m = PSC_MASK_8;
            3'h3:    m = PSC_MASK_64;
            3'h4:    m = PSC_MASK_256;
            3'h5:    m = PSC_MASK_1024;
            default: run = 1'b0;
        endcase
        return run && ((cnt & m) == m);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    logic [3:0]    mode;
    logic [1:0]    act [2];
    logic          tick;
    logic          pwm;
    logic [CW-1:0] top;
    logic          top_hit;
    logic [1:0]    hit;
    logic          do_wr;
    logic [AW-1:0] ra;
    logic [CW-1:0] wv;
    logic [3:0]    set_flags;

    always_comb begin
        s_d       = s_q;
        mode      = s_q.ctrl[MODE_LSB +: 4];
        act[0]    = s_q.ctrl[ACT_A_LSB +: 2];
        act[1]    = s_q.ctrl[ACT_B_LSB +: 2];
        pwm       = is_fpwm(mode);
        set_flags = 4'h0;
        ra        = s_axi_araddr;
        wv        = CNT_BOT;

        // free prescaler
        s_d.psc = s_q.psc + 10'h001;
        // RULE_23 prescale tap
        tick = psc_tick(s_q.ctrl[PSC_LSB +: 3], s_q.psc);

        // RULE_06 RULE_13 RULE_22 top choice
        unique case (mode)
            MODE_CTC_CMP, MODE_FPWM_CMP: top = s_q.cmp_a;
            MODE_CTC_CAP, MODE_FPWM_CAP: top = s_q.cap;
            MODE_FPWM_8:                 top = TOP_8BIT;
            MODE_FPWM_9:                 top = TOP_9BIT;
            MODE_FPWM_10:                top = TOP_10BIT;
            default:                     top = CNT_MAX;
        endcase
        // RULE_07 RULE_20 unbuffered top, exact match only
        top_hit = (s_q.cnt == top);
        // a count write blocks matches for one tick
        hit[0] = (s_q.cnt == s_q.cmp_a) && !s_q.block;
        hit[1] = (s_q.cnt == s_q.cmp_b) && !s_q.block;

        ////////////////////////////////////////////////////////////////////////////
        // timer step, only on ticks

        // RULE_27 tick gating
        if (tick) begin
            s_d.block = 1'b0;
            // RULE_25 match flags
            set_flags[FLG_MA] = hit[0];
            set_flags[FLG_MB] = hit[1];
            if (pwm) begin
                // RULE_12 RULE_14 single slope
                if (top_hit && !s_q.block) begin
                    s_d.cnt = CNT_BOT;
                    // RULE_17 overflow and top flags
                    set_flags[FLG_OVF] = 1'b1;
                    if (mode == MODE_FPWM_CAP) begin
                        set_flags[FLG_CAP] = 1'b1;
                    end
                    if (mode == MODE_FPWM_CMP) begin
                        set_flags[FLG_MA] = 1'b1;
                    end
                    // RULE_19 buffer copy at top
                    s_d.cmp_a = s_q.buf_a;
                    s_d.cmp_b = s_q.buf_b;
                end else begin
                    s_d.cnt = s_q.cnt + 16'h0001;
                end
            end else if (mode == MODE_CTC_CMP || mode == MODE_CTC_CAP) begin
                // RULE_06 clear at top
                if (top_hit && !s_q.block) begin
                    s_d.cnt = CNT_BOT;
                    // RULE_08 top flag
                    if (mode == MODE_CTC_CAP) begin
                        set_flags[FLG_CAP] = 1'b1;
                    end else begin
                        set_flags[FLG_MA] = 1'b1;
                    end
                end else begin
                    s_d.cnt = s_q.cnt + 16'h0001;
                end
                // RULE_11 overflow at max
                set_flags[FLG_OVF] = (s_q.cnt == CNT_MAX);
            end else begin
                // RULE_03 plain up count
                s_d.cnt = s_q.cnt + 16'h0001;
                // RULE_04 overflow on wrap
                set_flags[FLG_OVF] = (s_q.cnt == CNT_MAX);
            end

            // RULE_01 outputs only
            for (int i = 0; i < 2; i++) begin
                if (!pwm) begin
                    // RULE_02 RULE_09 non-pwm match action
                    if (hit[i]) begin
                        unique case (act[i])
                            ACT_TOGGLE: s_d.oc[i] = !s_q.oc[i];
                            ACT_CLEAR:  s_d.oc[i] = 1'b0;
                            ACT_SET:    s_d.oc[i] = 1'b1;
                            // RULE_24 no action
                            ACT_NONE:   s_d.oc[i] = s_q.oc[i];
                        endcase
                    end
                end else if (act[i] == ACT_TOGGLE) begin
                    // toggle only on a with a-defined top
                    if (i == 0 && mode == MODE_FPWM_CMP && hit[i]) begin
                        s_d.oc[i] = !s_q.oc[i];
                    end
                end else if (act[i] != ACT_NONE) begin
                    // RULE_15 RULE_16 polarity on match then bottom
                    if (hit[i]) begin
                        s_d.oc[i] = (act[i] == PWM_INVERT_ACTION);
                    end
                    // bottom wins: compare at top is constant
                    if (top_hit && !s_q.block) begin
                        s_d.oc[i] = (act[i] != PWM_INVERT_ACTION);
                    end
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////////
        // axi4-lite write side

        if (s_axi_awvalid && !s_q.aw_full) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_full) begin
            s_d.w_full = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        do_wr = s_q.aw_full && s_q.w_full && !s_q.bvalid;
        if (do_wr) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            unique case (s_q.aw_addr)
                OFS_TIMER_CTRL_A: begin
                    s_d.ctrl = merge16(s_q.ctrl, s_q.w_data, s_q.w_strb) & CTRL_MASK;
                end
                OFS_COUNT_VALUE: begin
                    // RULE_05 load any time, wins over the tick
                    s_d.cnt   = merge16(s_q.cnt, s_q.w_data, s_q.w_strb);
                    s_d.block = 1'b1;
                end
                OFS_CHAN_A_COMPARE: begin
                    // RULE_18 fixed top mask
                    wv = merge16(s_q.buf_a, s_q.w_data, s_q.w_strb) & fixed_mask(mode);
                    s_d.buf_a = wv;
                    // RULE_19 direct only outside pwm
                    if (!pwm) begin
                        s_d.cmp_a = wv;
                    end
                end
                OFS_CHAN_B_COMPARE: begin
                    // RULE_18 fixed top mask
                    wv = merge16(s_q.buf_b, s_q.w_data, s_q.w_strb) & fixed_mask(mode);
                    s_d.buf_b = wv;
                    if (!pwm) begin
                        s_d.cmp_b = wv;
                    end
                end
                OFS_CAPTURE_VALUE: begin
                    // RULE_20 immediate top
                    s_d.cap = merge16(s_q.cap, s_q.w_data, s_q.w_strb);
                end
                OFS_TIMER_FLAG_REG: begin
                    // RULE_25 write one clears
                    if (s_q.w_strb[0]) begin
                        s_d.flags = s_q.flags & ~s_q.w_data[3:0];
                    end
                end
                OFS_WAVE_PIN_DIR: begin
                    if (s_q.w_strb[0]) begin
                        s_d.dir = s_q.w_data[1:0];
                    end
                end
                default: begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        // hardware set beats w1c
        s_d.flags = s_d.flags | set_flags;

        ////////////////////////////////////////////////////////////////////////////
        // axi4-lite read side

        if (s_axi_rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            unique case (ra)
                OFS_TIMER_CTRL_A:   s_d.rdata[CW-1:0] = s_q.ctrl;
                OFS_COUNT_VALUE:    s_d.rdata[CW-1:0] = s_q.cnt;
                OFS_CHAN_A_COMPARE: s_d.rdata[CW-1:0] = s_q.buf_a;
                OFS_CHAN_B_COMPARE: s_d.rdata[CW-1:0] = s_q.buf_b;
                OFS_CAPTURE_VALUE:  s_d.rdata[CW-1:0] = s_q.cap;
                OFS_TIMER_FLAG_REG: s_d.rdata[3:0]    = s_q.flags;
                OFS_WAVE_PIN_DIR:   s_d.rdata[1:0]    = s_q.dir;
                default:            s_d.rresp         = RESP_SLVERR;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // RULE_26 compare state cleared
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign s_axi_awready = !s_q.aw_full;
    assign s_axi_wready  = !s_q.w_full;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    assign chan_wave_out = s_q.oc;
    assign timer_flags   = s_q.flags;

    // out from port unless an action is set
    // RULE_10 direction gate
    always_comb begin
        wave_pins.oe = s_q.dir;
        for (int i = 0; i < 2; i++) begin
            wave_pins.out[i] = (s_q.ctrl[ACT_A_LSB + 2*i +: 2] != ACT_NONE) ?
                               s_q.oc[i] : port_data[i];
        end
    end

endmodule

/* File: dv/timer16_assertions.sv */
`timescale 1ns/1ps
module timer16_checker
    import timer16_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins and timer state
    input wire logic [1:0]  port_data,
    input wire wave_pins_t  wave_pins,
    input wire logic [1:0]  chan_wave_out,
    input wire logic [3:0]  timer_flags
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_clears: assert property (
        $rose(aresetn) |-> chan_wave_out == 2'h0 && timer_flags == 4'h0 && wave_pins.oe == 2'h0)
        else $error("state not cleared by reset");
    a_pin_source: assert property (
        ((wave_pins.out ^ chan_wave_out) & (wave_pins.out ^ port_data)) == 2'h0)
        else $error("bad pin source");
    a_flag_clear_cause: assert property (
        ($past(timer_flags) & ~timer_flags) != 4'h0 |-> $rose(s_axi_bvalid))
        else $error("flag cleared without write");
    a_bvalid_holds: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rvalid_holds: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
        |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered in time");
    a_rdata_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    c_overflow: cover property ($rose(timer_flags[0]));
    c_toggle: cover property ($changed(chan_wave_out[0]));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

/* File: dv/pin_load.sv */
`timescale 1ns/1ps
module pin_load
    import timer16_pkg::*;
(
    // clock
    input  wire logic       aclk,
    // pins from the device
    input  wire wave_pins_t wave_pins,
    // level seen by the load
    output      logic [1:0] pin_level
);
    logic [1:0] float_q;

    // undriven pin shows the inverse
    always_ff @(posedge aclk) begin
        float_q <= ~pin_level;
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_level[i] = wave_pins.oe[i] ? wave_pins.out[i] : float_q[i];
        end
    end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import timer16_pkg::*;
;
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]    s_axi_awprot, s_axi_arprot;
    logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic          s_axi_rvalid, s_axi_rready;
    logic [31:0]   s_axi_wdata, s_axi_rdata;
    logic [3:0]    s_axi_wstrb, timer_flags;
    logic [1:0]    s_axi_bresp, s_axi_rresp, port_data, chan_wave_out, pin_level;
    wave_pins_t    wave_pins;
    int            err_total = 0;
    int            comparisons = 0;
    int            cycles = 0;
    int            divs [6] = '{0, 1, 8, 64, 256, 1024};
    logic [3:0]    fm [3] = '{MODE_FPWM_8, MODE_FPWM_9, MODE_FPWM_10};
    logic [15:0]   ft [3] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};

    timer16_waveform_modes dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_data,
        .wave_pins, .chan_wave_out, .timer_flags);
    pin_load load (.aclk, .wave_pins, .pin_level);

    always #12.5 aclk = ~aclk;

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_total++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    function automatic int exp_half(int c, int t);
        return divs[c] * (1 + t);
    endfunction

    task automatic wr(input logic [AW-1:0] a, input logic [15:0] d, input logic [1:0] er);
        bit a_ok = 0;
        bit w_ok = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            a_ok |= s_axi_awready;
            w_ok |= s_axi_wready;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("bresp", s_axi_bresp, er);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check("rresp", s_axi_rresp, er);
    endtask

    // load stopped, flags cleared
    task automatic setup(input logic [3:0] m, input logic [1:0] act, input logic [15:0] top,
                         input logic [15:0] cmp, input int c);
        wr(OFS_TIMER_CTRL_A, {8'h00, 2'h0, act, m}, RESP_OKAY);
        wr(OFS_CAPTURE_VALUE, top, RESP_OKAY);
        wr(OFS_CHAN_A_COMPARE, (m == MODE_FPWM_CAP) ? cmp : top, RESP_OKAY);
        wr(OFS_COUNT_VALUE, 16'h0000, RESP_OKAY);
        wr(OFS_TIMER_FLAG_REG, 16'h000F, RESP_OKAY);
        wr(OFS_WAVE_PIN_DIR, 16'h0003, RESP_OKAY);
        wr(OFS_TIMER_CTRL_A, {5'h00, 3'(c), 2'h0, act, m}, RESP_OKAY);
    endtask

    // skip the partial first segment
    task automatic measure(output int hi, output int per);
        hi = 0;
        while (pin_level[0] !== 1'b0) @(posedge aclk);
        while (pin_level[0] !== 1'b1) @(posedge aclk);
        while (pin_level[0] === 1'b1) begin
            @(posedge aclk);
            hi++;
        end
        per = hi;
        while (pin_level[0] === 1'b0) begin
            @(posedge aclk);
            per++;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d, v;
        int hi, per, t, p, q;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        port_data = 2'h0;
        void'($urandom(85244));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        port_data <= 2'($urandom);
        @(posedge aclk);
        check("pin_out", wave_pins.out, port_data);
        check("pin_oe", wave_pins.oe, 0);
        rd(OFS_TIMER_FLAG_REG, RESP_OKAY, d);
        check("flags_rst", d, 0);
        rd(8'h1C, RESP_SLVERR, d);
        check("unmapped_rd", d, 0);
        wr(8'h1C, 16'h1234, RESP_SLVERR);
        wr(OFS_COUNT_VALUE, 16'hFFF0, RESP_OKAY);
        rd(OFS_COUNT_VALUE, RESP_OKAY, d);
        check("cnt_load", d, 32'h0000_FFF0);
        wr(OFS_TIMER_CTRL_A, 16'h0100, RESP_OKAY);
        // wrap after sixteen ticks
        repeat (40) @(posedge aclk);
        rd(OFS_TIMER_FLAG_REG, RESP_OKAY, d);
        check("ovf_set", d[FLG_OVF], 1);
        rd(OFS_COUNT_VALUE, RESP_OKAY, d);
        check("cnt_wrap", d[15:7], 0);
        wr(OFS_TIMER_CTRL_A, 16'h0000, RESP_OKAY);
        wr(OFS_TIMER_FLAG_REG, 16'h0001, RESP_OKAY);
        rd(OFS_TIMER_FLAG_REG, RESP_OKAY, d);
        check("ovf_w1c", d[FLG_OVF], 0);
        for (int i = 0; i < 3; i++) begin
            v = $urandom;
            wr(OFS_TIMER_CTRL_A, {12'h000, fm[i]}, RESP_OKAY);
            wr(OFS_CHAN_B_COMPARE, v[15:0], RESP_OKAY);
            rd(OFS_CHAN_B_COMPARE, RESP_OKAY, d);
            check("cmp_mask", d, v[15:0] & ft[i]);
        end
        for (int c = 1; c <= 5; c++) begin
            t = 3 + $urandom % 4;
            setup(c[0] ? MODE_CTC_CAP : MODE_CTC_CMP, ACT_TOGGLE, t[15:0], 16'h0000, c);
            measure(hi, per);
            check("ctc_half", hi, exp_half(c, t));
            check("ctc_period", per, 2 * exp_half(c, t));
            rd(OFS_TIMER_FLAG_REG, RESP_OKAY, d);
            check("ctc_flag", {d[FLG_CAP], d[FLG_MA]}, {c[0], 1'b1});
        end
        for (int i = 0; i < 2; i++) begin
            p = 8 + $urandom % 32;
            q = 1 + $urandom % (p - 1);
            setup(MODE_FPWM_CAP, i ? ACT_SET : ACT_CLEAR, p[15:0], q[15:0], 1);
            measure(hi, per);
            check("pwm_high", hi, i ? q + 1 : p - q);
            check("pwm_period", per, p + 1);
        end
        rd(OFS_TIMER_FLAG_REG, RESP_OKAY, d);
        check("pwm_flags", {d[FLG_CAP], d[FLG_OVF]}, 2'b11);
        wr(OFS_WAVE_PIN_DIR, 16'h0000, RESP_OKAY);
        check("pin_off", wave_pins.oe, 0);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("oc_rst", chan_wave_out, 0);
        end_sim();
    end
endmodule

bind timer16_waveform_modes timer16_checker chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .port_data,
    .wave_pins, .chan_wave_out, .timer_flags);
